// ==== core/ipi_fail_pkg.sv ====
// Package: constants for the incomplete IPI exit reporter
package ipi_fail_pkg;
   localparam logic [11:0] INCOMPLETE_IPI_EXIT_CODE = 12'h401; // Arbitrary code value
   // Cause codes
   localparam logic [31:0] CAUSE_BAD_TYPE      = 32'h0000_0000;
   localparam logic [31:0] CAUSE_NOT_RUNNING   = 32'h0000_0001;
   localparam logic [31:0] CAUSE_BAD_TARGET    = 32'h0000_0002;
   localparam logic [31:0] CAUSE_BAD_PAGE      = 32'h0000_0003;
   localparam logic [31:0] CAUSE_BAD_VECTOR    = 32'h0000_0004;
   localparam logic [31:0] CAUSE_UNACCEL       = 32'h0000_0005;
   localparam logic [31:0] CAUSE_MAX           = 32'h0000_0005;
   // Limits
   localparam logic [7:0]  VECTOR_MIN          = 8'h10;
   localparam logic [15:0] LOGICAL_CLUSTER_MAX = 16'h0040;
   localparam logic [15:0] EXT_CLUSTER_MAX     = 16'h001F;
   localparam logic [15:0] LEGACY_ID_MAX       = 16'h00FF;
   localparam logic [15:0] PHYS_TARGET_MAX     = 16'h0200;
   // Field positions
   localparam int          INDEX_W             = 9;
   localparam int          CAUSE_LSB           = 32;
   // Register offsets
   localparam logic [3:0]  OFS_FIRST_LO  = 4'h0;
   localparam logic [3:0]  OFS_FIRST_HI  = 4'h4;
   localparam logic [3:0]  OFS_SECOND_LO = 4'h8;
   localparam logic [3:0]  OFS_SECOND_HI = 4'hC;
   // Status bit positions and status/mask reset values
   localparam int          ST_EXIT   = 0;
   localparam int          ST_REPORT = 1;
   localparam logic [1:0]  STAT_RESET = 2'h0;
   localparam logic [1:0]  MASK_RESET = 2'h0;
   // Shorthand encodings
   localparam logic [1:0]  SH_NONE   = 2'h0;
   localparam logic [1:0]  SH_SELF   = 2'h1;
endpackage

// ==== core/ipi_cause_sel.sv ====
// Cause classifier: picks the failure cause code and index in priority order
`timescale 1ns/1ps
module ipi_cause_sel
   import ipi_fail_pkg::*;
(
   input  wire logic        level_trig,
   input  wire logic        bad_dest_type,
   input  wire logic        secure_mode,
   input  wire logic [1:0]  shorthand,
   input  wire logic [7:0]  ipi_vector,
   input  wire logic        logical_mode,
   input  wire logic        ext_mode,
   input  wire logic [15:0] logical_group_number,
   input  wire logic [15:0] guest_core_identifier,
   input  wire logic [15:0] phys_target,
   input  wire logic        entry_absent,
   input  wire logic        page_bad,
   input  wire logic        vcpu_scheduled_flag,
   input  wire logic [8:0]  target_index,
   input  wire logic [8:0]  phys_index,
   output logic             fail,
   output logic [31:0]      cause,
   output logic [8:0]       index
);
   logic bad_target;
   // Invalid target checks per destination mode
   always_comb begin
      if (logical_mode) begin
         bad_target = (logical_group_number > LOGICAL_CLUSTER_MAX)
                    | (ext_mode & (logical_group_number > EXT_CLUSTER_MAX))
                    | (!ext_mode & (guest_core_identifier > LEGACY_ID_MAX))
                    | entry_absent;
      end else begin
         bad_target = (phys_target > PHYS_TARGET_MAX) | entry_absent;
      end
   end
   // Type, secure-mode and vector faults first: they make the index meaningless
   always_comb begin
      fail  = 1'b1;
      cause = CAUSE_BAD_TYPE;
      index = '0;
      if (level_trig | bad_dest_type) begin
         cause = CAUSE_BAD_TYPE;
      end else if (secure_mode && shorthand != SH_SELF) begin
         cause = CAUSE_UNACCEL;
      end else if (ipi_vector < VECTOR_MIN) begin
         cause = CAUSE_BAD_VECTOR;
      end else if (bad_target) begin
         cause = CAUSE_BAD_TARGET;
         index = target_index;
      end else if (page_bad) begin
         cause = CAUSE_BAD_PAGE;
         index = (shorthand != SH_NONE) ? phys_index : target_index;
      end else if (!vcpu_scheduled_flag) begin
         cause = CAUSE_NOT_RUNNING;
         index = target_index;
      end else begin
         fail = 1'b0;
      end
   end
endmodule

// ==== core/ipi_delivery_failure_report.sv ====
// Incomplete IPI guest exit reporter with exit-information words and interrupt
// What this block does
// - Unscheduled target causes guest exit with the incomplete IPI exit code.
// - High command half goes into bits 63:32 of first exit word.
// - Low command half goes into bits 31:0 of first exit word.
// - Failure cause code sits in bits 63:32 of second exit word.
// - Index in bits 8:0 only for codes one to three; rest zero.
// - Level trigger or unsupported destination type gives code 0.
// - Clear scheduled flag gives code 1 with the target's entry index.
// - Logical mode target invalid past cluster or identifier limits, code 2.
// - Physical target above 512 or absent entry gives code 2.
// - Invalid backing page pointer gives code 3.
// - Code 3 indexes physical entry for shorthand, else per destination mode.
// - Vector below 16 gives code 4, index reserved.
// - Secure mode, shorthand not self, gives code 5.
// - Set pending bit, without a doorbell, in the same cycle as the exit for unscheduled targets.
// - Broadcast skips invalid entries in physical mode; directed or logical invalid entry causes exit.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module ipi_delivery_failure_report
   import ipi_fail_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Delivery attempt
   input  wire logic        req_valid,
   input  wire logic [31:0] int_cmd_high_half,
   input  wire logic [31:0] int_cmd_low_half,
   input  wire logic        broadcast,
   input  wire logic        bad_dest_type,
   input  wire logic        secure_mode,
   input  wire logic        logical_mode,
   input  wire logic        ext_mode,
   input  wire logic [15:0] logical_group_number,
   input  wire logic [15:0] guest_core_identifier,
   input  wire logic [15:0] phys_target,
   input  wire logic        entry_absent,
   input  wire logic        page_bad,
   input  wire logic        vcpu_scheduled_flag,
   input  wire logic [8:0]  target_index,
   input  wire logic [8:0]  phys_index,
   // Side effects for valid destinations
   output logic             pending_set,
   output logic [7:0]       ipi_vector,
   output logic             doorbell,
   // Exit event
   output logic             guest_exit_event,
   output logic [11:0]      exit_code,
   output logic [63:0]      exit_detail_first,
   output logic [63:0]      exit_detail_second,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             irq
);
   typedef struct packed {
      logic        pend;
      logic        bell;
      logic [7:0]  vec;
      logic        exit;
      logic [63:0] first;
      logic [63:0] second;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic [31:0] rdata;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic        fail;
   logic [31:0] cause;
   logic [8:0]  index;
   logic        is_level;
   logic [1:0]  shorthand;
   logic        skip;
   logic [1:0]  sel_shorthand;

   // Command fields: vector low byte, trigger bit 15, shorthand bits 19:18
   assign is_level  = int_cmd_low_half[15];
   assign shorthand = int_cmd_low_half[19:18];
   // Broadcast in physical mode passes over an invalid entry instead of failing
   assign skip      = broadcast & entry_absent & !logical_mode;
   // Broadcast indexes like a shorthand; code 3 never equals self, so secure check is unchanged
   assign sel_shorthand = (broadcast && shorthand == SH_NONE) ? 2'h3 : shorthand;

   ipi_cause_sel u_sel (
      .level_trig            (is_level),
      .bad_dest_type         (bad_dest_type),
      .secure_mode           (secure_mode),
      .shorthand             (sel_shorthand),
      .ipi_vector            (int_cmd_low_half[7:0]),
      .logical_mode          (logical_mode),
      .ext_mode              (ext_mode),
      .logical_group_number  (logical_group_number),
      .guest_core_identifier (guest_core_identifier),
      .phys_target           (phys_target),
      .entry_absent          (entry_absent & !skip),
      .page_bad              (page_bad),
      .vcpu_scheduled_flag   (vcpu_scheduled_flag),
      .target_index          (target_index),
      .phys_index            (phys_index),
      .fail                  (fail),
      .cause                 (cause),
      .index                 (index)
   );

   // Next state; set wins over a write-one-to-clear in the same cycle
   always_comb begin
      s_d      = s_q;
      s_d.pend = 1'b0;
      s_d.bell = 1'b0;
      s_d.exit = 1'b0;
      s_d.rdata = '0;
      if (req_valid && !skip) begin
         // Valid destination not blocked by an earlier fault
         if (!fail || cause == CAUSE_NOT_RUNNING) begin
            s_d.pend = 1'b1;
            s_d.vec  = int_cmd_low_half[7:0];
            s_d.bell = vcpu_scheduled_flag;
         end
      end
      if (reg_wr && reg_addr == OFS_SECOND_HI) begin
         s_d.stat = s_q.stat & ~reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == OFS_SECOND_LO) begin
         s_d.mask = reg_wdata[1:0];
      end
      if (req_valid && !skip && fail && cause <= CAUSE_MAX) begin
         s_d.exit   = 1'b1;
         s_d.first  = {int_cmd_high_half, int_cmd_low_half};
         s_d.second = {cause, 23'h000000, index};
         s_d.stat[ST_EXIT] = 1'b1;
         if (cause == CAUSE_NOT_RUNNING) begin
            s_d.stat[ST_REPORT] = 1'b1;
         end
      end
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_FIRST_LO:  s_d.rdata = s_q.first[31:0];
            OFS_FIRST_HI:  s_d.rdata = s_q.first[63:32];
            OFS_SECOND_LO: s_d.rdata = s_q.second[31:0];
            OFS_SECOND_HI: s_d.rdata = s_q.second[63:32];
            default:       s_d.rdata = {28'h0000000, s_q.mask, s_q.stat};
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pending_set        = s_q.pend;
   assign ipi_vector         = s_q.vec;
   assign doorbell           = s_q.bell;
   assign guest_exit_event   = s_q.exit;
   assign exit_code          = INCOMPLETE_IPI_EXIT_CODE;
   assign exit_detail_first  = s_q.first;
   assign exit_detail_second = s_q.second;
   assign reg_rdata          = s_q.rdata;
   assign irq                = |(s_q.stat & s_q.mask);
endmodule

// ==== test/ipi_props.sv ====
// Checker: port properties of the incomplete IPI exit reporter
`timescale 1ns/1ps
module ipi_props
   import ipi_fail_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic        req_valid,
   input wire logic [31:0] int_cmd_high_half,
   input wire logic [31:0] int_cmd_low_half,
   input wire logic        bad_dest_type,
   input wire logic        secure_mode,
   input wire logic        vcpu_scheduled_flag,
   input wire logic        pending_set,
   input wire logic        guest_exit_event,
   input wire logic [11:0] exit_code,
   input wire logic [63:0] exit_detail_first,
   input wire logic [63:0] exit_detail_second
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Cause field of the second word
   wire [31:0] cause = exit_detail_second[63:32];
   // Exit one cycle after the attempt, with the given cause
   sequence s_exit(logic [31:0] c);
      ##1 guest_exit_event && cause == c;
   endsequence
   a_exit_code: assert property (exit_code == INCOMPLETE_IPI_EXIT_CODE)
      else $error("exit code wrong");
   a_exit_cause: assert property (guest_exit_event |-> $past(req_valid))
      else $error("exit without attempt");
   a_cmd_high: assert property (guest_exit_event |-> exit_detail_first[63:32] == $past(int_cmd_high_half))
      else $error("high command half wrong");
   a_cmd_low: assert property (guest_exit_event |-> exit_detail_first[31:0] == $past(int_cmd_low_half))
      else $error("low command half wrong");
   a_detail_hold: assert property (!guest_exit_event |-> $stable(exit_detail_second))
      else $error("detail changed without exit");
   a_cause_max: assert property (cause <= CAUSE_MAX)
      else $error("cause above five");
   a_index_resv: assert property (guest_exit_event |-> exit_detail_second[31:9] == 23'h0 && (cause inside {[1:3]} || exit_detail_second[8:0] == 9'h0))
      else $error("reserved index bits set");
   a_type_code: assert property (req_valid && (int_cmd_low_half[15] || bad_dest_type) |-> s_exit(CAUSE_BAD_TYPE))
      else $error("type fault not code 0");
   a_low_vector: assert property (req_valid && !int_cmd_low_half[15] && !bad_dest_type && !secure_mode && int_cmd_low_half[7:0] < VECTOR_MIN |-> s_exit(CAUSE_BAD_VECTOR))
      else $error("low vector not code 4");
   a_unsched_pend: assert property (guest_exit_event && cause == CAUSE_NOT_RUNNING |-> pending_set && !$past(vcpu_scheduled_flag))
      else $error("unscheduled exit without pending set");
endmodule
bind ipi_delivery_failure_report ipi_props u_props (.*);

// ==== test/testbench.sv ====
// Self-checking bench for the incomplete IPI exit reporter
`timescale 1ns/1ps
module testbench;
   import ipi_fail_pkg::*;
   logic clk_sys, arst_n, req_valid, broadcast, bad_dest_type, secure_mode, logical_mode;
   logic ext_mode, entry_absent, page_bad, vcpu_scheduled_flag, reg_wr, reg_rd, rd_q;
   logic pending_set, doorbell, guest_exit_event, irq;
   logic [31:0] int_cmd_high_half, int_cmd_low_half, reg_wdata, reg_rdata, hi, lo, qr[$];
   logic [15:0] logical_group_number, guest_core_identifier, phys_target;
   logic [8:0]  target_index, phys_index, ti, pi, qv[$];
   logic        nopend;
   logic [3:0]  reg_addr;
   logic [7:0]  ipi_vector;
   logic [11:0] exit_code;
   logic [63:0] exit_detail_first, exit_detail_second, lf, ls, q1[$], q2[$];
   int          err_total, tests_run, cyc;
   integer      seed = 69928;
   ipi_delivery_failure_report uut (.*);
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Fault-free attempt; random fields stay inside every limit
   task automatic clean;
      hi = $random(seed);
      lo = $random(seed);
      lo[19:18] = SH_NONE;
      lo[15] = 1'h0;
      lo[7:0] = 8'h10 | 8'($random(seed));
      ti = 9'($random(seed));
      pi = ~ti;
      nopend = 1'h0;
      {broadcast, bad_dest_type, secure_mode, logical_mode, ext_mode} <= 5'h0;
      {entry_absent, page_bad, vcpu_scheduled_flag} <= 3'h1;
      phys_target <= 16'h0200;
      logical_group_number <= 16'h001F & 16'($random(seed));
      guest_core_identifier <= 16'h00FF;
   endtask
   task automatic go(input logic e, input logic [31:0] c, input logic [8:0] i);
      {int_cmd_high_half, int_cmd_low_half, target_index, phys_index} <= {hi, lo, ti, pi};
      req_valid <= 1'h1;
      // Pending side effect for clean or unscheduled attempts: doorbell, vector
      if (!nopend && (!e || c == CAUSE_NOT_RUNNING)) qv.push_back({c != CAUSE_NOT_RUNNING, lo[7:0]});
      if (e) begin
         lf = {hi, lo};
         ls = {c, 23'h0, i};
         q1.push_back(lf);
         q2.push_back(ls);
      end
      @(posedge clk_sys);
      req_valid <= 1'h0;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
      if (!w) qr.push_back(d);
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'h0;
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Scoreboard: oldest note against each exit or read answer
   always @(posedge clk_sys) begin
      if (guest_exit_event === 1'h1) begin
         if (q1.size() == 0) chk(64'h1, 64'h0);
         else begin
            chk(exit_code, INCOMPLETE_IPI_EXIT_CODE);
            chk(exit_detail_first, q1.pop_front());
            chk(exit_detail_second, q2.pop_front());
         end
      end
      if (pending_set === 1'h1) begin
         if (qv.size() == 0) chk(64'h1, 64'h0);
         else chk({doorbell, ipi_vector}, qv.pop_front());
      end
      if (rd_q) chk(reg_rdata, qr.pop_front());
      rd_q <= reg_rd;
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         end_of_test();
      end
   end
   // Main sequence: at most one fault per attempt, then the register side
   initial begin
      {arst_n, req_valid, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
      clean();
      {int_cmd_high_half, int_cmd_low_half, target_index, phys_index} = 0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'h1;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk_sys);
         clean();
         case (k)
            0: go(0, 0, 0);
            1: begin lo[15] = 1'h1; go(1, CAUSE_BAD_TYPE, 0); end
            2: begin bad_dest_type <= 1'h1; go(1, CAUSE_BAD_TYPE, 0); end
            3: begin secure_mode <= 1'h1; go(1, CAUSE_UNACCEL, 0); end
            4: begin secure_mode <= 1'h1; lo[19:18] = SH_SELF; go(0, 0, 0); end
            5: begin lo[7:0] = 8'h0F; go(1, CAUSE_BAD_VECTOR, 0); end
            6: begin logical_mode <= 1'h1; guest_core_identifier <= 16'h0100; go(1, CAUSE_BAD_TARGET, ti); end
            7: begin {logical_mode, ext_mode} <= 2'h3; logical_group_number <= 16'h0020; go(1, CAUSE_BAD_TARGET, ti); end
            8: begin pi = ti; phys_target <= 16'h0201; go(1, CAUSE_BAD_TARGET, ti); end
            9: begin pi = ti; entry_absent <= 1'h1; go(1, CAUSE_BAD_TARGET, ti); end
            10: begin page_bad <= 1'h1; go(1, CAUSE_BAD_PAGE, ti); end
            11: begin page_bad <= 1'h1; lo[19:18] = 2'h2; go(1, CAUSE_BAD_PAGE, pi); end
            12: begin nopend = 1'h1; {broadcast, entry_absent} <= 2'h3; go(0, 0, 0); end
            13: begin logical_mode <= 1'h1; go(0, 0, 0); end
            15: begin {broadcast, page_bad} <= 2'h3; go(1, CAUSE_BAD_PAGE, pi); end
            default: begin pi = ti; vcpu_scheduled_flag <= 1'h0; go(1, CAUSE_NOT_RUNNING, ti); end
         endcase
      end
      bus(0, OFS_FIRST_LO, lf[31:0]);
      bus(0, OFS_FIRST_HI, lf[63:32]);
      bus(0, OFS_SECOND_LO, ls[31:0]);
      bus(0, OFS_SECOND_HI, ls[63:32]);
      bus(0, 4'h2, 32'h3);
      bus(1, OFS_SECOND_LO, 32'h1);
      bus(0, 4'h2, 32'h7);
      chk(irq, 1'h1);
      bus(1, OFS_SECOND_HI, 32'h3);
      bus(0, 4'h2, 32'h4);
      chk(irq, 1'h0);
      // Let the last read answer reach the scoreboard before closing
      repeat (2) @(posedge clk_sys);
      chk(q1.size(), 0);
      chk(qr.size(), 0);
      chk(qv.size(), 0);
      end_of_test();
   end
endmodule
